/* core/tcc_defines.svh */
// Constants for the timer clock control block: register map, fields, resets.
// Assumes inclusion by bare name from the package and design modules.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_ADDR_CTRL    4'h0
`define TCC_ADDR_COUNT   4'h4
`define TCC_ADDR_TOGGLE  4'h8
`define TCC_CTRL_RESET   8'h00
`define TCC_CTRL_WMASK   8'hFD
`define TCC_SRC_TOUCH    2'h3
`define TCC_SRC_PIN      2'h2
`define TCC_SRC_SYS      2'h1
`define TCC_SRC_QUARTER  2'h0
`define TCC_QDIV_LAST    2'h3
`define TCC_READ_ERR     32'hDEADBEEF
`define TCC_RESP_OK      2'h0
`define TCC_RESP_ERR     2'h2
`endif

/* core/tcc_pkg.sv */
// Types shared by the timer clock control block.
// Assumes tcc_defines.svh sits on the include path.
`include "tcc_defines.svh"
package tcc_pkg;
  typedef struct packed {
    logic [1:0] source_sel;
    logic [1:0] prescale_sel;
    logic       osc_en;
    logic       sync_bypass_n;
    logic       unused;
    logic       counter_on;
  } tcc_ctrl_t;

  typedef struct packed {
    logic touch_sense_oscillator;
    logic external_count_clock_pin;
    logic dedicated_osc_clk;
    logic gate_edge;
  } tcc_pins_t;
endpackage

/* core/tcc_prescaler.sv */
// Prescaler: divides count-clock ticks by 1, 2, 4 or 8.
// Assumes tick_in is a one-cycle pulse on sys_clk.
`include "tcc_defines.svh"
module tcc_prescaler #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Control
  input  wire logic             clear,
  input  wire logic [1:0]       sel,
  input  wire logic             tick_in,
  // Result
  output logic                  tick_out
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             out_reg;
  logic             out_next;
  logic [WIDTH-1:0] limit;

  always_comb begin
    limit    = WIDTH'((1 << sel) - 1);
    cnt_next = cnt_reg;
    out_next = 1'b0;
    if (clear) begin
      cnt_next = '0;
    end else if (tick_in) begin
      if (cnt_reg >= limit) begin
        cnt_next = '0;
        out_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign tick_out = out_reg;
endmodule

/* core/tcc_top.sv */
// Timer clock control: control register, source select, prescale, counter.
// Assumes pin and oscillator inputs are asynchronous to sys_clk.
`include "tcc_defines.svh"
module tcc_top #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic [1:0]                avs_response,
  // Count sources
  input  wire tcc_pkg::tcc_pins_t   pins,
  // Status
  output logic [CW-1:0]             count_value,
  output logic                      gate_toggle,
  output logic                      dedicated_osc_drive
);
  import tcc_pkg::*;

  tcc_ctrl_t   ctrl_reg;
  tcc_ctrl_t   ctrl_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic        tog_reg;
  logic        tog_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        wait_reg;
  logic        wait_next;
  logic [1:0]  resp_reg;
  logic [1:0]  resp_next;
  logic [3:0]  s1_reg;
  logic [3:0]  s2_reg;
  logic [3:0]  s3_reg;
  logic [1:0]  q_reg;
  logic [1:0]  q_next;
  logic        osc_reg;
  logic        raw_tick;
  logic        scaled_tick;
  logic [3:0]  rise;
  logic        acc;

  // Two-stage synchroniser per pin, then a third stage for edge detection.
  // Only the second and third stages feed logic; the first may still be settling.
  for (genvar g = 0; g < $bits(tcc_pins_t); g++) begin : g_sync
    logic s1_next;
    logic s2_next;
    logic s3_next;

    always_comb begin
      s1_next = pins[g];
      s2_next = s1_reg[g];
      s3_next = s2_reg[g];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        s1_reg[g] <= 1'b0;
        s2_reg[g] <= 1'b0;
        s3_reg[g] <= 1'b0;
      end else begin
        s1_reg[g] <= s1_next;
        s2_reg[g] <= s2_next;
        s3_reg[g] <= s3_next;
      end
    end

    // Rising edge of the synchronised level
    assign rise[g] = s2_reg[g] & ~s3_reg[g];
  end

  assign acc  = avs_read | avs_write;

  // Bus decode
  logic            take;
  logic            answer;
  logic            hit_ctrl;
  logic            hit_count;
  logic            wr_ctrl;
  logic            wr_count;
  // Counter write enables, one per byte lane
  logic [CW/8-1:0] wr_lane;

  // A request is taken at the first edge, while waitrequest is high, and
  // answered at the second; writes land only at the answer edge.
  always_comb begin
    take      = acc && wait_reg;
    answer    = acc && !wait_reg;
    hit_ctrl  = (avs_address == `TCC_ADDR_CTRL);
    hit_count = (avs_address == `TCC_ADDR_COUNT);
    wr_ctrl   = answer && avs_write && hit_ctrl && avs_byteenable[0];
    wr_count  = answer && avs_write && hit_count;
  end

  for (genvar b = 0; b < CW / 8; b++) begin : g_lane
    assign wr_lane[b] = wr_count && avs_byteenable[b];
  end

  // Quarter-rate group: a tick every fourth cycle stands in for the
  // instruction clock, so no second clock domain is needed
  always_comb begin
    q_next = q_reg + 2'h1;
  end

  // Source select; the pin and oscillator paths are always synchronised
  // here, so the bypass bit is stored but cannot remove the latency.
  always_comb begin
    case (ctrl_reg.source_sel)
      `TCC_SRC_TOUCH:   raw_tick = rise[3];
      `TCC_SRC_PIN: begin
        if (ctrl_reg.osc_en) begin
          raw_tick = rise[1];
        end else begin
          raw_tick = rise[2];
        end
      end
      `TCC_SRC_SYS:     raw_tick = 1'b1;
      `TCC_SRC_QUARTER: raw_tick = (q_reg == `TCC_QDIV_LAST);
      default:          raw_tick = 1'b0;
    endcase
  end

  tcc_prescaler #(
    .WIDTH (3)
  ) u_presc (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .clear    (~ctrl_reg.counter_on),
    .sel      (ctrl_reg.prescale_sel),
    .tick_in  (raw_tick & ctrl_reg.counter_on),
    .tick_out (scaled_tick)
  );

  // Counter group
  always_comb begin
    cnt_next = cnt_reg;
    if (ctrl_reg.counter_on && scaled_tick) begin
      cnt_next = cnt_reg + CW'(1);
    end
    // Software write to the counter takes precedence over a tick
    for (int b = 0; b < CW / 8; b++) begin
      if (wr_lane[b]) begin
        cnt_next[b*8 +: 8] = avs_writedata[b*8 +: 8];
      end
    end
  end

  // Gate toggle group: held clear while the counter is off, so software
  // knows which gate edge the next measurement starts from
  always_comb begin
    tog_next = tog_reg;
    if (ctrl_reg.counter_on && rise[0]) begin
      tog_next = ~tog_reg;
    end
    if (!ctrl_reg.counter_on) begin
      tog_next = 1'b0;
    end
  end

  // Read-back mux; unmapped offsets answer with an error code
  logic [31:0] rd_sel;
  logic [1:0]  resp_sel;

  always_comb begin
    rd_sel   = 32'h0;
    resp_sel = `TCC_RESP_OK;
    case (avs_address)
      `TCC_ADDR_CTRL: begin
        rd_sel[7:0] = ctrl_reg;
      end
      `TCC_ADDR_COUNT: begin
        rd_sel[CW-1:0] = cnt_reg;
      end
      `TCC_ADDR_TOGGLE: begin
        rd_sel[0] = tog_reg;
      end
      default: begin
        resp_sel = `TCC_RESP_ERR;
        rd_sel   = `TCC_READ_ERR;
      end
    endcase
  end

  // Bus group: one wait cycle per access, answer at the second edge
  always_comb begin
    ctrl_next = ctrl_reg;
    rd_next   = rd_reg;
    resp_next = resp_reg;
    wait_next = 1'b1;
    if (take) begin
      wait_next = 1'b0;
      resp_next = resp_sel;
      rd_next   = rd_sel;
    end
    // Control writes land at the answer edge, as counter writes do
    if (wr_ctrl) begin
      ctrl_next = avs_writedata[7:0] & `TCC_CTRL_WMASK;
    end
  end

  // Bus group registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `TCC_CTRL_RESET;
      rd_reg   <= 32'h0;
      wait_reg <= 1'b1;
      resp_reg <= `TCC_RESP_OK;
    end else begin
      ctrl_reg <= ctrl_next;
      rd_reg   <= rd_next;
      wait_reg <= wait_next;
      resp_reg <= resp_next;
    end
  end

  // Counter and gate toggle registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      tog_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_next;
    end
  end

  // Quarter-rate divider register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= 2'h0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Oscillator drive follows the enable bit at the edge where it lands
  logic osc_next;

  always_comb begin
    osc_next = ctrl_next.osc_en;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      osc_reg <= 1'b0;
    end else begin
      osc_reg <= osc_next;
    end
  end

  assign avs_readdata        = rd_reg;
  assign avs_waitrequest     = wait_reg;
  assign avs_response        = resp_reg;
  assign count_value         = cnt_reg;
  assign gate_toggle         = tog_reg;
  assign dedicated_osc_drive = osc_reg;
endmodule

/* sim/tcc_src.sv */
// Far side: pin clock, crystal and touch oscillator.
// Assumes the crystal swings only while the block drives it.
module tcc_src (
  input  wire logic               sys_clk,
  input  wire logic               gate,
  input  wire logic               drv,
  output wire tcc_pkg::tcc_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic [5:0] c_reg = 6'h00;
  always @(posedge sys_clk) c_reg <= c_reg + 6'h01;
  assign pins = {c_reg[5], c_reg[4], c_reg[3] & drv, gate};
endmodule

/* sim/tcc_chk.sv */
// Port checker of tcc_top: source choice, rate and stop.
// Assumes lane 0 is enabled on every control write.
module tcc_chk #(parameter int CW = 16) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               rstn,
  // Bus, pins, status
  input wire logic [3:0]         avs_address,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic               avs_waitrequest,
  input wire tcc_pkg::tcc_pins_t pins,
  input wire logic [CW-1:0]      count_value,
  input wire logic               gate_toggle
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic [7:0]    sh_reg, sh_next, ph_reg, ph_next;
  logic [3:0]    q_reg, q_next;
  logic [CW-1:0] pv_reg;
  logic          wr, mv;
  always_comb begin
    wr = avs_write && (avs_waitrequest ? avs_address == 4'h4
                                       : avs_address == 4'h0);
    sh_next = wr && !avs_waitrequest ? avs_writedata[7:0] & 8'hFD : sh_reg;
    q_next = wr ? 4'h0 : q_reg + {3'h0, q_reg != 4'hF};
    // History of the picked source covers the synchroniser delay
    ph_next = {ph_reg[6:0], sh_reg[7:6] == 2'h3 ?
      pins.touch_sense_oscillator : sh_reg[3] ?
      pins.dedicated_osc_clk : pins.external_count_clock_pin};
    mv = count_value != pv_reg;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_reg <= 8'h00;
      ph_reg <= 8'h00;
      q_reg <= 4'h0;
      pv_reg <= '0;
    end else begin
      sh_reg <= sh_next;
      ph_reg <= ph_next;
      q_reg <= q_next;
      pv_reg <= count_value;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_touch;
    q_reg > 8 && sh_reg == 8'hC1 && mv |-> |ph_reg[6:1];
  endproperty
  a_touch: assert property (p_touch) else $error("touch count");
  property p_osc;
    q_reg > 8 && sh_reg == 8'h89 && mv |-> |ph_reg[6:1];
  endproperty
  a_osc: assert property (p_osc) else $error("crystal count");
  property p_pin;
    q_reg > 8 && sh_reg == 8'h81 && mv |-> |ph_reg[6:1];
  endproperty
  a_pin: assert property (p_pin) else $error("pin count");
  property p_off;
    q_reg > 4 && !sh_reg[0] |-> !mv && !gate_toggle;
  endproperty
  a_off: assert property (p_off) else $error("stopped count");
  property p_sys;
    q_reg > 4 && sh_reg == 8'h41 |-> count_value == pv_reg + 1'b1;
  endproperty
  a_sys: assert property (p_sys) else $error("system rate");
  c_sys: cover property (q_reg == 4'hF && sh_reg == 8'h41);
  c_osc: cover property (sh_reg == 8'h89 && mv);
  c_off: cover property (q_reg > 4 && !sh_reg[0]);
endmodule
bind tcc_top tcc_chk #(.CW(CW)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .pins(pins), .count_value(count_value), .gate_toggle(gate_toggle));

/* sim/timer_clock_control_register_tb.sv */
// Bench for tcc_top: reset values, map, all sources and prescales, stop.
// Assumes tcc_chk is bound to the design by its own file.
module timer_clock_control_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wt, drv;
  logic [3:0]  adr = 4'h0;
  logic [1:0]  rsp, rr;
  logic [7:0]  c;
  logic [31:0] wd = 32'h0, rdat, rx, a, seed = 32'h00EE, gs = 32'h00EE;
  tcc_pins_t   pins;
  int          n_errors = 0, n_checks = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Source rises in 64 cycles, after prescale
  function automatic logic [31:0] ex(input logic [7:0] k);
    logic [31:0] b;
    b = k[7] ? (k[6] ? 32'h1 : k[3] ? 32'h4 : 32'h2)
             : (k[6] ? 32'h40 : 32'h10);
    return b >> k[5:4];
  endfunction
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) gs <= xs(gs);
  tcc_src u_src (.sys_clk(sys_clk), .gate(gs[9]), .drv(drv), .pins(pins));
  tcc_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt),
    .avs_response(rsp), .pins(pins), .count_value(),
    .gate_toggle(), .dedicated_osc_drive(drv));
  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] d);
    @(posedge sys_clk);
    adr <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge sys_clk); while (wt !== 1'b0);
    rx = rdat;
    rr = rsp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, e, input logic tl);
    n_checks++;
    if (g !== e && !(tl && (g === e + 32'h1 || g === e - 32'h1))) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(0, 4'h0, 32'h0);
    chk(rx, 32'h0, 0);
    bus(0, 4'hC, 32'h0);
    chk(rx, 32'hDEADBEEF, 0);
    chk({30'h0, rr}, 32'h2, 0);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      c = {i[4:0], 1'b0, seed[0], 1'b1};
      bus(1, 4'h0, {24'h0, c});
      bus(0, 4'h0, 32'h0);
      chk(rx, {24'h0, c & 8'hFD}, 0);
      bus(0, 4'h4, 32'h0);
      a = rx;
      repeat (61) @(posedge sys_clk);
      bus(0, 4'h4, 32'h0);
      chk((rx - a) & 32'hFFFF, ex(c), 1);
      bus(1, 4'h0, {24'h0, c & 8'hFE});
      bus(1, 4'h4, seed >> 16);
      repeat (9) @(posedge sys_clk);
      bus(0, 4'h4, 32'h0);
      chk(rx, seed >> 16, 0);
      bus(0, 4'h8, 32'h0);
      chk(rx, 32'h0, 0);
    end
    $display("test sources done");
    close_out;
  end
  initial begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
